// *** logic/adc_ctrl_consts.svh ***
// Operation
// RL1: bits launch on falling shift clock edge, sampled on the next rising edge.
// RL2: half duplex: channel word comes in first, result goes out afterwards.
// RL3: while select is high, serial input shifts into 4-bit word on rising edges.
// RL4: extra bits allowed; only the last four before select falls are kept.
// RL5: host drops select before the next rising edge after the last word bit.
// RL6: on select fall, all channels off after off delay, then a gap, then on.
// RL7: after conversion starts, one null bit, then result bits shift out.
// RL8: latched channel stays connected until the next select fall.
// RL9: host raises select at exchange end; device returns to idle.
// RL10: a rising select starts a transfer; word bits accepted only after it.
// RL11: first word bit is enable; high switches addressed channel on after on delay.
// RL12: enable low switches all channels off after off delay until next fall.
// RL13: converter select high powers down, output high impedance; low converts.
// RL14: switch select high accepts address; low connects the addressed channel.
// RL15: host normally drives both selects together; separate driving is allowed.
// RL16: one shift clock times both serial transfers and paces the conversion.
// RL17: converter powers down automatically whenever no conversion runs.
// RL18: host may tie serial input and output together for three wires.
// RL19: converter makes a 12-bit result from a sample-and-hold stage.
// RL20: four- and eight-channel variants; decoding follows the built count.
// RL21: three bits after enable are the channel number, msb first.
// RL22: sampling ends, hold and conversion begin, on second falling edge after select low.
// RL23: conversion takes twelve shift clock cycles after the hold edge.
// RL24: while select is low the latched word is kept and serial input ignored.
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

// ==========================================================
// word layout
`define WORD_W 4
`define EN_BIT 3
`define CH_HI 2
`define CH_LO 0
`define CHAN_W 8
`define CHANNELS_BUILT 8
`define CHANNELS_SMALL 4

// ==========================================================
// converter
`define RESULT_W 12
`define TRIAL_MSB 12'h800
`define EDGE_W 5
`define EDGE_ENABLE 5'h01
`define EDGE_HOLD 5'h02
`define EDGE_LAST 5'h0e
`define EDGE_DONE 5'h0f

// ==========================================================
// switch timing
`define SEQ_W 8
`define SYS_PERIOD_NS 5
`define T_OFF_NS 500
`define T_OPEN_NS 125

`endif

// *** logic/adc_ctrl_pkg.sv ***
`include "adc_ctrl_consts.svh"

package adc_ctrl_pkg;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_BREAK = 2'b01,
		ST_OPEN = 2'b10,
		ST_CONNECT = 2'b11
	} switch_state_e;

	typedef struct packed
	{
		switch_state_e st;
		logic sel_prev;
		logic [`SEQ_W-1:0] cnt;
		logic [`WORD_W-1:0] word;
		logic [`CHAN_W-1:0] chan_on;
	} switch_s;

	typedef struct packed
	{
		logic [`EDGE_W-1:0] edge_cnt;
		logic [`RESULT_W-1:0] code;
		logic dout;
		logic oe;
		logic hold;
		logic power;
	} conv_s;

	typedef struct packed
	{
		logic [`WORD_W-1:0] word;
	} word_s;

endpackage

// *** logic/mux_adc_serial_control.sv ***
`timescale 1ns/1ps
`include "adc_ctrl_consts.svh"

module mux_adc_serial_control #(
	parameter int CHANNEL_COUNT = `CHANNELS_BUILT
)
(
	input wire logic SYS_CLK,
	input wire logic RSTN,
	input wire logic CLK_EN,
	input wire logic SHIFT_CLK,
	input wire logic CHANNEL_SWITCH_SELECT_N,
	input wire logic CONVERTER_SELECT_N,
	input wire logic SERIAL_IN,
	input wire logic COMPARATOR_HIGH,
	output logic SERIAL_OUT,
	output logic SERIAL_OUT_EN,
	output logic SAMPLE_HOLD,
	output logic CONVERTER_POWER,
	output logic [`RESULT_W-1:0] TRIAL_CODE,
	output logic [`CHAN_W-1:0] CHANNEL_ON
);

	// ==========================================================
	// timing counts
	localparam int OFF_CYC = `T_OFF_NS / `SYS_PERIOD_NS;
	localparam int OPEN_CYC = (`T_OPEN_NS + `SYS_PERIOD_NS - 1) / `SYS_PERIOD_NS;
	localparam int OFF_SEEN = OFF_CYC + 1;
	localparam logic [`SEQ_W-1:0] OFF_LAST = `SEQ_W'(OFF_CYC - 1);
	localparam logic [`SEQ_W-1:0] OPEN_LAST = `SEQ_W'(OPEN_CYC - 1);

	// ==========================================================
	// crossings
	logic en_l;
	logic sel_s;
	logic [`WORD_W-1:0] word_s;
	logic conv_rst_n;
	adc_ctrl_pkg::word_s w_q;
	adc_ctrl_pkg::word_s w_d;

	// the link domain is frozen too; idles enabled so no word bit is lost
	sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_en_sync
	(
		.clk(SHIFT_CLK),
		.rst_n(RSTN),
		.en(1'b1),
		.d(CLK_EN),
		.q(en_l)
	);

	sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sel_sync
	(
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.en(CLK_EN),
		.d(CHANNEL_SWITCH_SELECT_N),
		.q(sel_s)
	);

	// word is stable while the switch select is low, so a plain bus sync is safe
	sync2 #(.WIDTH(`WORD_W), .RST_VAL('0)) u_word_sync
	(
		.clk(SYS_CLK),
		.rst_n(RSTN),
		.en(CLK_EN),
		.d(w_q.word),
		.q(word_s)
	);

	// ==========================================================
	// channel word, shift clock rising edge

	always_comb
	begin
		w_d = w_q;
		if (en_l && CHANNEL_SWITCH_SELECT_N)
			w_d.word = {w_q.word[`WORD_W-2:0], SERIAL_IN}; // RL3 RL4 RL1 RL10 RL14
	end

	// select low: word frozen, input ignored
	always_ff @(posedge SHIFT_CLK or negedge RSTN)
	begin
		if (!RSTN)
			w_q <= '0;
		else
			w_q <= w_d; // RL24 RL2
	end

	// ==========================================================
	// conversion and result, shift clock falling edge
	adc_ctrl_pkg::conv_s c_q;
	adc_ctrl_pkg::conv_s c_d;
	logic [`EDGE_W-1:0] next_edge;
	logic [3:0] bit_pos;

	// converter select high resets the exchange and powers down
	assign conv_rst_n = RSTN & ~CONVERTER_SELECT_N; // RL13 RL9

	always_comb
	begin
		c_d = c_q;
		next_edge = c_q.edge_cnt;
		bit_pos = 4'h0;
		if (en_l && c_q.edge_cnt != `EDGE_DONE)
		begin
			next_edge = c_q.edge_cnt + `EDGE_ENABLE;
			c_d.edge_cnt = next_edge;
			if (next_edge == `EDGE_ENABLE)
			begin
				c_d.oe = 1'b1;
				c_d.power = 1'b1;
				c_d.dout = 1'b0;
			end
			else if (next_edge == `EDGE_HOLD)
			begin
				c_d.hold = 1'b1; // RL22
				c_d.dout = 1'b0; // RL7
				c_d.code = `TRIAL_MSB;
			end
			else if (next_edge <= `EDGE_LAST)
			begin
				// one successive-approximation decision per shift clock
				bit_pos = 4'(`EDGE_LAST - next_edge); // RL16 RL23
				c_d.code[bit_pos] = COMPARATOR_HIGH; // RL19
				c_d.dout = COMPARATOR_HIGH; // RL7 RL1
				if (bit_pos != 4'h0)
					c_d.code[4'(bit_pos - 4'h1)] = 1'b1;
				else
					c_d.power = 1'b0; // RL17
			end
			else
				c_d.dout = 1'b0;
		end
	end

	always_ff @(negedge SHIFT_CLK or negedge conv_rst_n)
	begin
		if (!conv_rst_n)
			c_q <= '0;
		else
			c_q <= c_d;
	end

	assign SERIAL_OUT = c_q.dout;
	assign SERIAL_OUT_EN = c_q.oe;
	assign SAMPLE_HOLD = c_q.hold;
	assign CONVERTER_POWER = c_q.power;
	assign TRIAL_CODE = c_q.code;

	// ==========================================================
	// channel switching, system clock
	adc_ctrl_pkg::switch_s s_q;
	adc_ctrl_pkg::switch_s s_d;
	logic sel_fall;

	function automatic logic [`CHAN_W-1:0] channel_decode(input logic [`WORD_W-1:0] w);
		logic [`CHAN_W-1:0] sel;
		sel = '0;
		if (w[`EN_BIT] && !(CHANNEL_COUNT == `CHANNELS_SMALL && w[`CH_HI]))
			sel[w[`CH_HI:`CH_LO]] = 1'b1; // RL20 RL21 RL11
		return sel;
	endfunction

	assign sel_fall = s_q.sel_prev & ~sel_s;

	always_comb
	begin
		s_d = s_q;
		if (CLK_EN)
		begin
			s_d.sel_prev = sel_s;
			if (sel_fall)
			begin
				s_d.st = adc_ctrl_pkg::ST_BREAK; // RL6 RL14
				s_d.cnt = '0;
				s_d.word = word_s;
			end
			else
			begin
				case (s_q.st)
					adc_ctrl_pkg::ST_BREAK:
					begin
						if (s_q.cnt == OFF_LAST)
						begin
							s_d.chan_on = '0; // RL6 RL12
							s_d.cnt = '0;
							if (s_q.word[`EN_BIT])
								s_d.st = adc_ctrl_pkg::ST_OPEN;
							else
								s_d.st = adc_ctrl_pkg::ST_IDLE; // RL12
						end
						else
							s_d.cnt = s_q.cnt + `SEQ_W'(1);
					end
					adc_ctrl_pkg::ST_OPEN:
					begin
						if (s_q.cnt == OPEN_LAST)
						begin
							s_d.chan_on = channel_decode(s_q.word); // RL6 RL11
							s_d.st = adc_ctrl_pkg::ST_CONNECT;
						end
						else
							s_d.cnt = s_q.cnt + `SEQ_W'(1);
					end
					default:
						s_d.st = s_q.st; // RL8
				endcase
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
			s_q <= '{st: adc_ctrl_pkg::ST_IDLE, sel_prev: 1'b1, cnt: '0, word: '0, chan_on: '0};
		else
			s_q <= s_d;
	end

	assign CHANNEL_ON = s_q.chan_on;

	// ==========================================================
	// assertions
	logic [`SEQ_W-1:0] dark_cnt_q;

	always_ff @(posedge SYS_CLK or negedge RSTN)
	begin
		if (!RSTN)
			dark_cnt_q <= '0;
		else if (CHANNEL_ON != '0)
			dark_cnt_q <= '0;
		else if (dark_cnt_q != '1)
			dark_cnt_q <= dark_cnt_q + `SEQ_W'(1);
	end

	property p_word_shift;
		@(posedge SHIFT_CLK) disable iff (!RSTN || !en_l)
		CHANNEL_SWITCH_SELECT_N |=> w_q.word == 4'({$past(w_q.word), $past(SERIAL_IN)});
	endproperty
	a_word_shift: assert property (p_word_shift) else $error("word did not shift"); // RL3

	property p_word_hold;
		@(posedge SHIFT_CLK) disable iff (!RSTN)
		!CHANNEL_SWITCH_SELECT_N |=> $stable(w_q.word);
	endproperty
	a_word_hold: assert property (p_word_hold) else $error("word changed while low"); // RL24

	property p_off_delay;
		@(posedge SYS_CLK) disable iff (!RSTN || !CLK_EN)
		sel_fall |-> ##OFF_SEEN CHANNEL_ON == '0;
	endproperty
	a_off_delay: assert property (p_off_delay) else $error("channels not off in time"); // RL6

	property p_open_gap;
		@(posedge SYS_CLK) disable iff (!RSTN)
		$rose(|CHANNEL_ON) |-> dark_cnt_q >= `SEQ_W'(OPEN_CYC);
	endproperty
	a_open_gap: assert property (p_open_gap) else $error("break-before-make gap short"); // RL6

	property p_enable_low;
		@(posedge SYS_CLK) disable iff (!RSTN)
		s_q.st == adc_ctrl_pkg::ST_IDLE |-> CHANNEL_ON == '0;
	endproperty
	a_enable_low: assert property (p_enable_low) else $error("channel on while disabled"); // RL12

	property p_connect_hold;
		@(posedge SYS_CLK) disable iff (!RSTN)
		s_q.st == adc_ctrl_pkg::ST_CONNECT && $past(s_q.st) == adc_ctrl_pkg::ST_CONNECT
			|-> $stable(CHANNEL_ON) && CHANNEL_ON == channel_decode(s_q.word);
	endproperty
	a_connect_hold: assert property (p_connect_hold) else $error("channel dropped"); // RL8

	property p_hiz;
		@(posedge SYS_CLK) disable iff (!RSTN)
		CONVERTER_SELECT_N |-> !SERIAL_OUT_EN && !CONVERTER_POWER;
	endproperty
	a_hiz: assert property (p_hiz) else $error("output driven while deselected"); // RL13

	property p_hold_edge;
		@(negedge SHIFT_CLK) disable iff (!conv_rst_n || !en_l)
		$rose(SAMPLE_HOLD) |-> c_q.edge_cnt == `EDGE_HOLD && SERIAL_OUT == 1'b0 && SERIAL_OUT_EN;
	endproperty
	a_hold_edge: assert property (p_hold_edge) else $error("hold or null bit misplaced"); // RL22

	property p_conv_len;
		@(negedge SHIFT_CLK) disable iff (!conv_rst_n || !en_l)
		$rose(SAMPLE_HOLD) |-> CONVERTER_POWER [*8] ##1 CONVERTER_POWER [*4] ##1 !CONVERTER_POWER;
	endproperty
	a_conv_len: assert property (p_conv_len) else $error("conversion length wrong"); // RL23

	property p_result_bits;
		@(negedge SHIFT_CLK) disable iff (!conv_rst_n || !en_l)
		c_q.edge_cnt > `EDGE_HOLD && c_q.edge_cnt <= `EDGE_LAST
			|-> SERIAL_OUT == $past(COMPARATOR_HIGH);
	endproperty
	a_result_bits: assert property (p_result_bits) else $error("result bit mismatch"); // RL7

	c_connect: cover property (@(posedge SYS_CLK) s_q.st == adc_ctrl_pkg::ST_CONNECT);
	c_dark: cover property (@(posedge SYS_CLK)
		s_q.st == adc_ctrl_pkg::ST_BREAK ##1 s_q.st == adc_ctrl_pkg::ST_IDLE);
	c_conv_done: cover property (@(negedge SHIFT_CLK) c_q.edge_cnt == `EDGE_DONE);
	c_long_word: cover property (@(posedge SHIFT_CLK) CHANNEL_SWITCH_SELECT_N [*5]);

endmodule

// *** logic/sync2.sv ***
`timescale 1ns/1ps

module sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	typedef struct packed
	{
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] stable;
	} stages_s;

	stages_s s_q;
	stages_s s_d;

	always_comb
	begin
		s_d = s_q;
		if (en)
		begin
			s_d.meta = d;
			s_d.stable = s_q.meta;
		end
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_q <= {RST_VAL, RST_VAL};
		else
			s_q <= s_d;
	end

	assign q = s_q.stable;

endmodule

// *** tb/host_model.sv ***
`timescale 1ns/1ps

// ==========================================================
// host master and analog comparator around the converter
module host_model
(
	input wire logic [11:0] TRIAL_CODE,
	output logic SHIFT_CLK,
	output logic CHANNEL_SWITCH_SELECT_N,
	output logic CONVERTER_SELECT_N,
	output logic SERIAL_IN,
	output logic COMPARATOR_HIGH
);
	logic [11:0] level;

	assign COMPARATOR_HIGH = level >= TRIAL_CODE;

	initial
	begin
		level = 12'h000;
		SHIFT_CLK = 1'b1;
		CHANNEL_SWITCH_SELECT_N = 1'b1;
		CONVERTER_SELECT_N = 1'b1;
		SERIAL_IN = 1'b0;
	end

	// ==========================================================
	// one shift clock period; data moves only on the falling edge
	task automatic tick(input logic b);
	begin
		#62.5 SHIFT_CLK = 1'b0;
		SERIAL_IN = CHANNEL_SWITCH_SELECT_N ? b : ~SERIAL_IN;
		#62.5 SHIFT_CLK = 1'b1;
	end
	endtask

	task automatic drop(input logic adc);
	begin
		#20 CHANNEL_SWITCH_SELECT_N = 1'b0;
		CONVERTER_SELECT_N = ~adc;
	end
	endtask

	task automatic raise();
	begin
		#20 CHANNEL_SWITCH_SELECT_N = 1'b1;
		CONVERTER_SELECT_N = 1'b1;
	end
	endtask
endmodule

// *** tb/mux_adc_serial_control_tb.sv ***
`timescale 1ns/1ps

module mux_adc_serial_control_tb;
	logic sys_clk;
	logic rstn;
	logic shift_clk, sw_sel_n, cv_sel_n, ser_in, cmp_high;
	logic ser_out, ser_oe, hold, power;
	logic [11:0] trial;
	logic [7:0] chan_on;
	logic [7:0] prev;
	logic data_line;
	int failures = 0;
	int n_tests = 0;
	int cycles = 0;

	// host and device share one data line in three-wire use
	assign data_line = ser_oe ? ser_out : ser_in;

	mux_adc_serial_control i_dut
	(
		.SYS_CLK(sys_clk),
		.RSTN(rstn),
		.CLK_EN(1'b1),
		.SHIFT_CLK(shift_clk),
		.CHANNEL_SWITCH_SELECT_N(sw_sel_n),
		.CONVERTER_SELECT_N(cv_sel_n),
		.SERIAL_IN(ser_in),
		.COMPARATOR_HIGH(cmp_high),
		.SERIAL_OUT(ser_out),
		.SERIAL_OUT_EN(ser_oe),
		.SAMPLE_HOLD(hold),
		.CONVERTER_POWER(power),
		.TRIAL_CODE(trial),
		.CHANNEL_ON(chan_on)
	);

	host_model i_host
	(
		.TRIAL_CODE(trial),
		.SHIFT_CLK(shift_clk),
		.CHANNEL_SWITCH_SELECT_N(sw_sel_n),
		.CONVERTER_SELECT_N(cv_sel_n),
		.SERIAL_IN(ser_in),
		.COMPARATOR_HIGH(cmp_high)
	);

	// ==========================================================
	// clock and hang guard
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 30000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// helpers
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
	begin
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	task automatic report_and_stop();
	begin
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask

	// ==========================================================
	// one exchange: word in, channel switching, then conversion out
	task automatic exchange(input logic [7:0] bits, input int n, input logic adc,
		input logic [11:0] lvl, input logic [7:0] exp_on);
		int k;
	begin
		i_host.level = lvl;
		for (k = n - 1; k >= 0; k--)
			i_host.tick(bits[k]);
		i_host.drop(adc);
		repeat (50) @(negedge sys_clk);
		check(chan_on, prev);
		repeat (60) @(negedge sys_clk);
		check(chan_on, 8'h00);
		repeat (30) @(negedge sys_clk);
		check(chan_on, exp_on);
		prev = exp_on;
		check(hold, 1'b0);
		for (k = 1; k <= 15; k++)
		begin
			i_host.tick(1'b0);
			if (k == 1)
				check(ser_oe, adc);
			if (k == 2)
				check(hold, adc);
			if (k == 2 || k == 15)
				check(ser_out, 1'b0);
			if (k >= 3 && k <= 14)
				check(ser_out, adc & lvl[14-k]);
			if (adc && k >= 3 && k <= 14)
				check(data_line, lvl[14-k]);
			if (k == 13)
				check(power, adc);
			if (k == 14)
				check(power, 1'b0);
		end
		check(trial, adc ? lvl : 12'h000);
		check(chan_on, exp_on);
		i_host.raise();
		#200;
		check(ser_oe, 1'b0);
	end
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rstn = 1'b0;
		prev = 8'h00;
		repeat (10) @(posedge sys_clk);
		@(negedge sys_clk) rstn = 1'b1;
		repeat (4) @(posedge sys_clk);
		for (int c = 0; c < 8; c++)
			exchange({4'h0, 1'b1, c[2:0]}, 4, 1'b1, 12'h5a3 ^ {c[3:0], 8'h3c}, 8'h01 << c);
		exchange(8'h5a, 7, 1'b1, 12'hfff, 8'h04);
		exchange(8'h06, 4, 1'b1, 12'h000, 8'h00);
		exchange(8'h0d, 4, 1'b0, 12'h000, 8'h20);
		exchange(8'h00, 0, 1'b1, 12'h801, 8'h20);
		report_and_stop();
	end
endmodule
